// >>> shared/pis_pkg.sv
package pis_pkg;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses on the plain register port)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_PA_IRQ_EN   = 8'h04;
  localparam logic [7:0] OFS_PB_IRQ_EN   = 8'h05;
  localparam logic [7:0] OFS_PA_IRQ_EDGE = 8'h06;
  localparam logic [7:0] OFS_PB_IRQ_EDGE = 8'h07;
  localparam logic [7:0] OFS_GLOBAL_EN   = 8'h20;
  localparam logic [7:0] OFS_EP_IRQ_EN   = 8'h21;
  localparam logic [7:0] OFS_PEND        = 8'h22;
  localparam logic [7:0] OFS_USB_CTRL    = 8'h23;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int GEN_SPI_BIT  = 3;
  localparam int GEN_MS_BIT   = 2;
  localparam int GEN_US_BIT   = 1;
  localparam int GEN_BUS_BIT  = 0;
  localparam int GEN_GPIO_BIT = 6;
  localparam int USB_SEL_BIT  = 0;
  localparam int EP_BITS      = 3;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ      = 25;
  localparam int TICK_US      = 128;
  localparam int TICKS_PER_MS = 8;
  localparam int TICK_CYC     = TICK_US * CLK_MHZ;
  localparam int BUS_MIN_US   = 256;
  localparam int BUS_TICKS    = BUS_MIN_US / TICK_US;

  // Priority vector encoding
  typedef enum logic [3:0] {
    PIS_VEC_NONE, PIS_VEC_BUS, PIS_VEC_US, PIS_VEC_MS, PIS_VEC_EP0,
    PIS_VEC_EP1, PIS_VEC_EP2, PIS_VEC_SPI, PIS_VEC_GPIO
  } pis_vec_t;

endpackage

// >>> core/pis_irq_sources.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// - Byte-complete event raises serial peripheral interrupt
// - Enabled 1.024 ms periodic timer interrupt
// - Enabled 128 us periodic timer interrupt
// - Mode bit selects bus reset or PS/2
// - Condition held 256 us raises interrupt
// - USB mode: interrupt when SE0 ends
// - PS/2 mode: interrupt on long low
// - Device address cleared during event interval
// - Interrupt may follow condition by 128 us
// - Endpoint enable register, three bits, reset zero
// - Endpoint OUT data interrupt, bad CRC in ACK
// - NAK or STALL handshake raises endpoint interrupt
// - Data endpoints interrupt on IN ACK
// - Control endpoint interrupts on SETUP accept
// - Control endpoint interrupts after zero-length status
// - Control endpoint OUT data interrupt rules
// - Write-only per-pin GPIO enables, reset zero
// - Write-only per-pin edge select, reset zero
// - Global enable bit layout, reset zero
// - One shared GPIO interrupt, pin lockout
// - Fixed priority bus, 128us, 1ms, EPs, SPI
module pis_irq_sources
  import pis_pkg::*;
#(
  parameter int PINS = 8                   // Pins per GPIO port
) (
  input  wire logic       I_MCLK,          // 25 MHz clock
  input  wire logic       I_RST,           // Sync reset, active high
  input  wire logic [7:0] I_ADDR,          // Register address
  input  wire logic [7:0] I_WDATA,         // Write data
  input  wire logic       I_WR,            // Write strobe
  input  wire logic       I_RD,            // Read strobe
  output logic      [7:0] O_RDATA,         // Read data, cycle after
  input  wire logic       I_SPI_DONE,      // Byte transfer complete pulse
  input  wire logic       I_USB_SE0,       // D+ and D- both low
  input  wire logic       I_PS2_DATA,      // PS/2 data pin level
  input  wire logic [2:0] I_EP_OUT_OK,     // Valid OUT data pulse
  input  wire logic [2:0] I_EP_OUT_ANY,    // OUT data, any CRC, pulse
  input  wire logic [2:0] I_EP_ACK_OUT,    // Endpoint in ACK OUT mode
  input  wire logic [2:0] I_EP_NAKSTALL,   // NAK/STALL sent pulse
  input  wire logic [2:0] I_EP_IN_ACK,     // IN ACK received pulse
  input  wire logic       I_EP0_SETUP,     // SETUP accepted pulse
  input  wire logic       I_EP0_ZLP,       // Zero-length status sent
  input  wire logic [PINS-1:0] I_GPIO_A,   // Port zero pin levels
  input  wire logic [PINS-1:0] I_GPIO_B,   // Port one pin levels
  input  wire logic       I_ACK,           // CPU acknowledge pulse
  output logic            O_TFLAG,         // Transfer complete flag
  output logic            O_ADDR_CLR,      // Clear USB device address
  output logic            O_IRQ,           // Interrupt request
  output logic      [3:0] O_VEC            // Highest pending vector
);

  // Wider ports would overrun the 8-bit write data
  if (PINS < 1 || PINS > 8) begin : g_bad_pins
    $error("PINS must be 1 to 8");
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [PINS-1:0] pa_en_reg;              // Port zero pin enables
  logic [PINS-1:0] pb_en_reg;              // Port one pin enables
  logic [PINS-1:0] pa_edge_reg;            // Port zero edge select
  logic [PINS-1:0] pb_edge_reg;            // Port one edge select
  logic [7:0]      gen_reg;                // Global enables
  logic [2:0]      ep_en_reg;              // Endpoint enables
  logic            sel_reg;                // 1 = PS/2, 0 = USB reset
  logic [7:0]      pend_reg;               // Pending sources
  logic [7:0]      rdata_reg;              // Read data
  logic            tflag_reg;              // Transfer complete flag

  // Write decode helper used for every register
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // ------------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      pa_en_reg   <= '0;
      pb_en_reg   <= '0;
      pa_edge_reg <= '0;
      pb_edge_reg <= '0;
      gen_reg     <= RST_BYTE;
      ep_en_reg   <= '0;
      sel_reg     <= 1'b0;
    end else if (I_WR) begin
      if (wr_hit(I_ADDR, OFS_PA_IRQ_EN)) begin
        pa_en_reg <= I_WDATA[PINS-1:0];
      end else if (wr_hit(I_ADDR, OFS_PB_IRQ_EN)) begin
        pb_en_reg <= I_WDATA[PINS-1:0];
      end else if (wr_hit(I_ADDR, OFS_PA_IRQ_EDGE)) begin
        pa_edge_reg <= I_WDATA[PINS-1:0];
      end else if (wr_hit(I_ADDR, OFS_PB_IRQ_EDGE)) begin
        pb_edge_reg <= I_WDATA[PINS-1:0];
      end else if (wr_hit(I_ADDR, OFS_GLOBAL_EN)) begin
        gen_reg <= I_WDATA;
      end else if (wr_hit(I_ADDR, OFS_EP_IRQ_EN)) begin
        ep_en_reg <= I_WDATA[EP_BITS-1:0];
      end else if (wr_hit(I_ADDR, OFS_USB_CTRL)) begin
        sel_reg <= I_WDATA[USB_SEL_BIT];
      end
    end
  end

  // ------------------------------------------------------------------
  // Read port; GPIO registers are write-only and read zero
  // ------------------------------------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      rdata_reg <= RST_BYTE;
    end else if (I_RD) begin
      if (wr_hit(I_ADDR, OFS_GLOBAL_EN)) begin
        rdata_reg <= gen_reg;
      end else if (wr_hit(I_ADDR, OFS_EP_IRQ_EN)) begin
        rdata_reg <= {5'h0, ep_en_reg};
      end else if (wr_hit(I_ADDR, OFS_PEND)) begin
        rdata_reg <= pend_reg;
      end else if (wr_hit(I_ADDR, OFS_USB_CTRL)) begin
        rdata_reg <= {6'h0, tflag_reg, sel_reg};
      end else begin
        rdata_reg <= RST_BYTE;                // Unmapped reads zero
      end
    end else begin
      rdata_reg <= RST_BYTE;
    end
  end
  assign O_RDATA = rdata_reg;

  // ------------------------------------------------------------------
  // Free-running timer: 128 us ticks, every eighth is 1.024 ms
  // ------------------------------------------------------------------
  localparam int TW = $clog2(TICK_CYC);
  logic [TW-1:0] div_reg;                  // Cycle divider
  logic [2:0]    tick_cnt_reg;             // 128 us tick count
  logic          tick_us;                  // 128 us tick
  logic          tick_ms;                  // 1.024 ms tick
  assign tick_us = div_reg == TW'(TICK_CYC - 1);
  assign tick_ms = tick_us && tick_cnt_reg == 3'(TICKS_PER_MS - 1);

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      div_reg      <= '0;
      tick_cnt_reg <= '0;
    end else begin
      div_reg <= tick_us ? '0 : div_reg + 1'b1;
      if (tick_us) begin
        tick_cnt_reg <= tick_cnt_reg + 1'b1;  // Wraps at eight
      end
    end
  end

  // ------------------------------------------------------------------
  // Bus activity detector, sampled on 128 us ticks; so detection
  // lands between 128 and 256 us after onset
  // ------------------------------------------------------------------
  logic       cond;                        // Selected condition
  logic [1:0] act_cnt_reg;                 // Ticks seen with condition
  logic       long_reg;                    // Condition held long
  logic       bus_evt;                     // Bus-activity event
  assign cond = sel_reg ? !I_PS2_DATA : I_USB_SE0;

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      act_cnt_reg <= '0;
      long_reg    <= 1'b0;
    end else if (!cond) begin
      act_cnt_reg <= '0;
      long_reg    <= 1'b0;            // Drops when condition ends
    end else if (tick_us && !long_reg) begin
      if (act_cnt_reg == 2'(BUS_TICKS - 1)) begin
        long_reg <= 1'b1;
      end else begin
        act_cnt_reg <= act_cnt_reg + 1'b1;
      end
    end
  end

  // USB reset fires as SE0 ends; PS/2 as soon as low is long
  assign bus_evt = sel_reg ? (cond && tick_us && !long_reg &&
                              act_cnt_reg == 2'(BUS_TICKS - 1))
                           : (long_reg && !cond);
  // Hold address clear for the whole event interval
  assign O_ADDR_CLR = long_reg || bus_evt;

  // ------------------------------------------------------------------
  // Transfer complete flag, cleared by reading control register
  // ------------------------------------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      tflag_reg <= 1'b0;
    end else if (I_SPI_DONE) begin
      tflag_reg <= 1'b1;              // Set wins over clear
    end else if (I_RD && wr_hit(I_ADDR, OFS_USB_CTRL)) begin
      tflag_reg <= 1'b0;
    end
  end
  assign O_TFLAG = tflag_reg;

  // ------------------------------------------------------------------
  // Endpoint events
  // ------------------------------------------------------------------
  logic [2:0] ep_evt;                      // Per-endpoint event
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ep
      logic data_evt;                      // OUT data event
      assign data_evt = I_EP_ACK_OUT[g] ? I_EP_OUT_ANY[g]
                                        : I_EP_OUT_OK[g];
      if (g == 0) begin : g_ctl
        assign ep_evt[g] = data_evt || I_EP_NAKSTALL[g] ||
                           I_EP0_SETUP || I_EP0_ZLP;
      end else begin : g_data
        assign ep_evt[g] = data_evt || I_EP_NAKSTALL[g] ||
                           I_EP_IN_ACK[g];
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // GPIO: armed pin edge, shared line locked while a pin is active
  // ------------------------------------------------------------------
  logic [2*PINS-1:0] pin_now;              // Current levels
  logic [2*PINS-1:0] pin_last_reg;         // Previous levels
  logic [2*PINS-1:0] pin_en;               // Enables
  logic [2*PINS-1:0] pin_pol;              // Edge select
  logic [2*PINS-1:0] pin_act;              // Pin at trigger level
  logic [2*PINS-1:0] lock_reg;             // Pin holds the line
  logic              gpio_evt;             // GPIO event
  assign pin_now = {I_GPIO_B, I_GPIO_A};
  assign pin_en  = {pb_en_reg, pa_en_reg};
  assign pin_pol = {pb_edge_reg, pa_edge_reg};
  assign pin_act = ~(pin_now ^ pin_pol) & pin_en;

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      pin_last_reg <= pin_now;        // No false edge after reset
      lock_reg     <= '0;
    end else begin
      pin_last_reg <= pin_now;
      if (lock_reg == '0) begin
        lock_reg <= pin_act & (pin_now ^ pin_last_reg);
      end else begin
        lock_reg <= lock_reg & pin_act;   // Free when inactive
      end
    end
  end
  assign gpio_evt = (lock_reg == '0) &&
                    ((pin_act & (pin_now ^ pin_last_reg)) != '0);

  // ------------------------------------------------------------------
  // Pending flags; set wins over acknowledge
  // ------------------------------------------------------------------
  logic [7:0] set_vec;                     // Enabled events
  logic [7:0] pend_next;                   // Next pending
  logic [7:0] ack_mask;                    // Served source
  assign set_vec = {gen_reg[GEN_GPIO_BIT] & gpio_evt,
                    gen_reg[GEN_SPI_BIT] & I_SPI_DONE,
                    ep_en_reg & ep_evt,
                    gen_reg[GEN_MS_BIT] & tick_ms,
                    gen_reg[GEN_US_BIT] & tick_us,
                    gen_reg[GEN_BUS_BIT] & bus_evt};

  always_comb begin
    ack_mask = '0;
    for (int i = 7; i >= 0; i--) begin
      if (pend_reg[i]) begin
        ack_mask = 8'h01 << i;        // Lowest index wins
      end
    end
    pend_next = ((pend_reg & ~(I_ACK ? ack_mask : 8'h00)) | set_vec);
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      pend_reg <= RST_BYTE;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // Vector of highest pending source
  always_comb begin
    O_VEC = PIS_VEC_NONE;
    for (int i = 7; i >= 0; i--) begin
      if (pend_reg[i]) begin
        O_VEC = 4'(i + 1);
      end
    end
  end
  assign O_IRQ = pend_reg != '0;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_spi_pend_set: assert property (@(posedge I_MCLK) disable iff (I_RST)
    I_SPI_DONE && gen_reg[GEN_SPI_BIT] |=> pend_reg[6] && O_TFLAG)
    else $error("serial interrupt not pending after byte");
  a_ms_tick_pend: assert property (@(posedge I_MCLK) disable iff (I_RST)
    tick_ms && gen_reg[GEN_MS_BIT] |=> pend_reg[2])
    else $error("ms timer event lost");
  a_us_tick_off: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !gen_reg[GEN_US_BIT] && !pend_reg[1] && !I_ACK |=> !pend_reg[1])
    else $error("disabled us timer set pending");
  a_addr_clr_hold: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_ADDR_CLR && cond |=> O_ADDR_CLR)
    else $error("address not cleared during event");
  a_usb_rst_end: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !sel_reg && long_reg && !I_USB_SE0 && gen_reg[GEN_BUS_BIT]
    |=> pend_reg[0])
    else $error("bus reset end not flagged");
  a_ep_en_read: assert property (@(posedge I_MCLK) disable iff (I_RST)
    I_RD && I_ADDR == OFS_EP_IRQ_EN |=> O_RDATA[7:3] == 5'h0)
    else $error("endpoint enable reserved bits nonzero");
  a_ep_nak_pend: assert property (@(posedge I_MCLK) disable iff (I_RST)
    I_EP_NAKSTALL[1] && ep_en_reg[1] |=> pend_reg[4])
    else $error("endpoint handshake event lost");
  a_bus_prio_top: assert property (@(posedge I_MCLK) disable iff (I_RST)
    pend_reg[0] |-> O_VEC == 4'(PIS_VEC_BUS))
    else $error("bus activity not top priority");

endmodule

// >>> tb/pis_cpu_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// CPU acknowledge model
// ------------------------------------------------------------------
// Takes the request after a short service delay, as a busy CPU would
module pis_cpu_model (
  input  wire logic i_mclk,  // Bench clock
  input  wire logic i_rst,   // Sync reset, active high
  input  wire logic i_irq,   // Request from the block
  output logic      o_ack    // One-cycle acknowledge pulse
);
  logic [1:0] wait_reg;      // Cycles the request has stood

  // Acknowledge once the request has stood four cycles
  always_ff @(posedge i_mclk) begin
    if (i_rst || !i_irq || o_ack) begin
      wait_reg <= 2'h0;
      o_ack    <= 1'b0;
    end else begin
      wait_reg <= wait_reg + 2'h1;
      o_ack    <= (wait_reg == 2'h3);
    end
  end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  import pis_pkg::*;
  logic       mclk, rst, wr, rd, spi, se0, ps2, setup, zlp, ack;
  logic [7:0] addr, wdata, rdata, ga, gb;
  logic [2:0] ook, oany, aout, nak, inack;
  logic       tflag, aclr, irq;
  logic [3:0] vec;
  int         n_errors = 0;
  int         samples_checked = 0;

  pis_irq_sources pis_irq_sources_i (.I_MCLK(mclk), .I_RST(rst),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_SPI_DONE(spi), .I_USB_SE0(se0), .I_PS2_DATA(ps2),
    .I_EP_OUT_OK(ook), .I_EP_OUT_ANY(oany), .I_EP_ACK_OUT(aout),
    .I_EP_NAKSTALL(nak), .I_EP_IN_ACK(inack), .I_EP0_SETUP(setup),
    .I_EP0_ZLP(zlp), .I_GPIO_A(ga), .I_GPIO_B(gb), .I_ACK(ack),
    .O_TFLAG(tflag), .O_ADDR_CLR(aclr), .O_IRQ(irq), .O_VEC(vec));
  pis_cpu_model pis_cpu_model_i (.i_mclk(mclk), .i_rst(rst), .i_irq(irq),
    .o_ack(ack));

  // ------------------------------------------------------------------
  // Clock, counting and verdict
  // ------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Compare one value, report at once
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (exp !== got) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ------------------------------------------------------------------
  // Register port tasks
  // ------------------------------------------------------------------
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(logic [7:0] a, logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 chk("rdata", exp, rdata);
  endtask

  // Bounded wait for a request, then check its vector
  task automatic wait_vec(logic [3:0] exp, int bound);
    int k;
    for (k = 0; k < bound; k++) begin
      @(posedge mclk);
      #1;
      if (irq === 1'b1) break;
    end
    if (k == bound) begin
      n_errors++;
      $display("Error irq expected 1 seen 0");
      give_verdict();
    end
    chk("vec", {4'h0, exp}, {4'h0, vec});
  endtask

  // Request must stay low for n cycles
  task automatic quiet(int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge mclk);
      #1 seen |= (irq !== 1'b0);
    end
    chk("quiet irq", 8'h00, {7'h0, seen});
  endtask

  // Let the model acknowledge everything pending; sample after the edge
  task automatic drain();
    int k;
    for (k = 0; k < 100 && irq !== 1'b0; k++) begin
      @(posedge mclk);
      #1;
    end
    chk("drained irq", 8'h00, {7'h0, irq});
    if (irq !== 1'b0) begin
      give_verdict();
    end
  endtask

  // One-cycle endpoint event, chosen by index
  task automatic ep_ev(int k);
    @(posedge mclk);
    case (k)
      0: ook[0] <= 1'b1;
      1: begin aout[1] <= 1'b1; oany[1] <= 1'b1; end
      2: nak[2] <= 1'b1;
      3: inack[1] <= 1'b1;
      4: inack[2] <= 1'b1;
      5: setup <= 1'b1;
      default: zlp <= 1'b1;
    endcase
    @(posedge mclk);
    {ook, oany, nak, inack, setup, zlp} <= '0;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    static int epv[7] = '{4, 5, 6, 5, 6, 4, 4};
    {wr, rd, spi, se0, setup, zlp} = '0;
    {ook, oany, aout, nak, inack} = '0;
    addr = 8'h00; wdata = 8'h00; ps2 = 1'b1; ga = 8'h02; gb = 8'h01;
    rst = 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    // Reset values, write-only and unmapped places read as zero
    rd_reg(OFS_GLOBAL_EN, 8'h00);
    rd_reg(OFS_EP_IRQ_EN, 8'h00);
    rd_reg(OFS_USB_CTRL, 8'h00);
    wr_reg(OFS_PA_IRQ_EN, 8'hff);
    rd_reg(OFS_PA_IRQ_EN, 8'h00);
    rd_reg(OFS_PB_IRQ_EDGE, 8'h00);
    rd_reg(8'h3c, 8'h00);
    wr_reg(OFS_PA_IRQ_EN, 8'h00);
    // Endpoint enables: reserved bits stay zero
    wr_reg(OFS_EP_IRQ_EN, 8'hff);
    rd_reg(OFS_EP_IRQ_EN, 8'h07);
    rd_reg(OFS_GLOBAL_EN, 8'h00);
    // Bad-CRC data outside ACK OUT mode is not an interrupt
    @(posedge mclk) oany[0] <= 1'b1;
    @(posedge mclk) oany[0] <= 1'b0;
    quiet(10);
    for (int k = 0; k < 7; k++) begin
      ep_ev(k);
      wait_vec(epv[k][3:0], 5);
      drain();
    end
    aout <= '0;
    // Serial byte done sets flag, flag clears on status read
    wr_reg(OFS_GLOBAL_EN, 8'h08);
    rd_reg(OFS_GLOBAL_EN, 8'h08);
    @(posedge mclk) spi <= 1'b1;
    @(posedge mclk) spi <= 1'b0;
    wait_vec(4'h7, 5);
    chk("tflag", 8'h01, {7'h0, tflag});
    drain();
    rd_reg(OFS_USB_CTRL, 8'h02);
    chk("tflag clr", 8'h00, {7'h0, tflag});
    // Endpoint and serial together: endpoint first
    @(posedge mclk) begin spi <= 1'b1; nak[0] <= 1'b1; end
    @(posedge mclk) begin spi <= 1'b0; nak[0] <= 1'b0; end
    #1 chk("prio vec", 8'h04, {4'h0, vec});
    // Endpoint zero is served first; let its acknowledge land
    repeat (6) @(posedge mclk);
    wait_vec(4'h7, 20);
    drain();
    rd_reg(OFS_USB_CTRL, 8'h02);
    // GPIO: shared request with lockout, per-pin edge choice
    wr_reg(OFS_GLOBAL_EN, 8'h40);
    wr_reg(OFS_PA_IRQ_EN, 8'h03);
    wr_reg(OFS_PA_IRQ_EDGE, 8'h01);
    @(posedge mclk) ga <= 8'h03;
    wait_vec(4'h8, 5);
    drain();
    @(posedge mclk) ga <= 8'h01;
    quiet(20);
    @(posedge mclk) ga <= 8'h02;
    quiet(5);
    @(posedge mclk) ga <= 8'h00;
    wait_vec(4'h8, 5);
    drain();
    wr_reg(OFS_PA_IRQ_EN, 8'h00);
    wr_reg(OFS_PB_IRQ_EN, 8'h01);
    @(posedge mclk) gb <= 8'h00;
    wait_vec(4'h8, 5);
    drain();
    wr_reg(OFS_PB_IRQ_EN, 8'h00);
    // PS/2 long low: request while still low, address held clear
    wr_reg(OFS_USB_CTRL, 8'h01);
    rd_reg(OFS_USB_CTRL, 8'h01);
    wr_reg(OFS_GLOBAL_EN, 8'h01);
    @(posedge mclk) ps2 <= 1'b0;
    wait_vec(4'h1, 3 * TICK_CYC + 20);
    chk("aclr ps2", 8'h01, {7'h0, aclr});
    drain();
    @(posedge mclk) ps2 <= 1'b1;
    quiet(TICK_CYC + 20);
    chk("aclr off", 8'h00, {7'h0, aclr});
    // USB bus reset: request only when the single-ended zero ends
    wr_reg(OFS_USB_CTRL, 8'h00);
    @(posedge mclk) se0 <= 1'b1;
    quiet(3 * TICK_CYC + 20);
    chk("aclr se0", 8'h01, {7'h0, aclr});
    @(posedge mclk) se0 <= 1'b0;
    wait_vec(4'h1, 5);
    drain();
    // Periodic timers, then both off as before suspend
    wr_reg(OFS_GLOBAL_EN, 8'h02);
    wait_vec(4'h2, TICK_CYC + 20);
    drain();
    wait_vec(4'h2, TICK_CYC + 20);
    wr_reg(OFS_GLOBAL_EN, 8'h04);
    drain();
    wait_vec(4'h3, TICKS_PER_MS * TICK_CYC + 20);
    wr_reg(OFS_GLOBAL_EN, 8'h00);
    drain();
    quiet(2 * TICK_CYC);
    give_verdict();
  end
endmodule
